// ### verilog/aoic_pkg.sv
/*
  Package for the area-of-interest and tap configuration command block.
  Holds register offsets, field positions, reset values, limits, step sizes,
  prompt codes and state encodings. Assumes a single 125 MHz system clock.
*/
package aoic_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [7:0] AOIC_REG_CMD     = 8'h00;
  localparam logic [7:0] AOIC_REG_ARG     = 8'h04;
  localparam logic [7:0] AOIC_REG_STATUS  = 8'h08;
  localparam logic [7:0] AOIC_REG_HEIGHT  = 8'h0c;
  localparam logic [7:0] AOIC_REG_WIDTH   = 8'h10;
  localparam logic [7:0] AOIC_REG_OFFY    = 8'h14;
  localparam logic [7:0] AOIC_REG_OFFX    = 8'h18;
  localparam logic [7:0] AOIC_REG_TAPS    = 8'h1c;
  localparam logic [7:0] AOIC_REG_MODE    = 8'h20;
  localparam logic [7:0] AOIC_REG_LIMITS  = 8'h24;

  // Command codes, three ASCII letters in bits 23:0, any case
  localparam logic [23:0] AOIC_CMD_HEIGHT = 24'h616968; // "aih"
  localparam logic [23:0] AOIC_CMD_WIDTH  = 24'h616977; // "aiw"
  localparam logic [23:0] AOIC_CMD_OFFY   = 24'h616979; // "aiy"
  localparam logic [23:0] AOIC_CMD_OFFX   = 24'h616978; // "aix"
  localparam logic [23:0] AOIC_CMD_CALIB  = 24'h636366; // "ccf"
  localparam logic [23:0] AOIC_CMD_TAPS   = 24'h636c6d; // "clm"
  localparam logic [23:0] AOIC_CASE_MASK  = 24'h202020;

  // Prompt codes reported in the status register
  localparam logic [2:0] AOIC_PR_OK      = 3'h0;
  localparam logic [2:0] AOIC_PR_UNKNOWN = 3'h1;
  localparam logic [2:0] AOIC_PR_RANGE   = 3'h2;
  localparam logic [2:0] AOIC_PR_NOTAVL  = 3'h3;

  // Status field positions
  localparam int AOIC_ST_BUSY_BIT  = 0;
  localparam int AOIC_ST_READY_BIT = 1;
  localparam int AOIC_ST_PR_LSB    = 4;

  // Flat-field mode values; only calibration allows the offset calibration
  localparam logic [1:0] AOIC_FFM_OFF = 2'h0;
  localparam logic [1:0] AOIC_FFM_ON  = 2'h1;
  localparam logic [1:0] AOIC_FFM_CAL = 2'h2;
  localparam int AOIC_MODE_FFM_LSB    = 0;
  localparam int AOIC_MODE_ASPECT_LSB = 4;

  // Limits and steps
  localparam logic [15:0] AOIC_MIN_HEIGHT = 16'h0002;
  localparam logic [15:0] AOIC_STEP_V     = 16'h0002;
  localparam logic [15:0] AOIC_MIN_WIDTH  = 16'h0200;
  localparam logic [15:0] AOIC_STEP_H     = 16'h0080;
  localparam logic [3:0]  AOIC_TAPS_8     = 4'h8;
  localparam logic [3:0]  AOIC_TAPS_10    = 4'ha;

  // Calibration run time, shortened through a top parameter in simulation
  localparam int AOIC_CAL_TIME_MS = 2000;
  localparam int AOIC_CLK_MHZ     = 125;
  localparam int AOIC_CAL_CYCLES  = AOIC_CAL_TIME_MS * 1000 * AOIC_CLK_MHZ;

  typedef enum logic [3:0] {
    AOIC_S_IDLE  = 4'b0001,
    AOIC_S_EXEC  = 4'b0010,
    AOIC_S_CALIB = 4'b0100,
    AOIC_S_FIT   = 4'b1000
  } aoic_state_t;

endpackage

// ### verilog/aoic_round_if.sv
/*
  Interface carrying one rounding-and-range-check request between the command
  engine and its arithmetic helper. Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface aoic_round_if;
  logic [15:0] value;
  logic [15:0] lo;
  logic [15:0] hi;
  logic [15:0] step;
  logic [15:0] result;
  logic        in_range;
  modport eng (output value, output lo, output hi, output step, input result, input in_range);
  modport alu (input value, input lo, input hi, input step, output result, output in_range);
endinterface

// ### verilog/aoic_round.sv
/*
  Combinational helper: rounds a value to the nearest multiple of a power-of-two
  step and checks it against a range. Assumes step is a power of two and lo, hi
  are themselves multiples of step.
*/
`timescale 1ns/10ps
module aoic_round (
  aoic_round_if.alu rif
);
  logic [16:0] sum;
  logic [15:0] rounded;
  logic [15:0] mask;

  // Round half up to the nearest step, saturating at the top of the word
  always_comb begin
    mask    = ~(rif.step - 16'h0001);
    sum     = {1'b0, rif.value} + {2'b00, rif.step[15:1]};
    rounded = sum[16] ? mask : (sum[15:0] & mask);
    rif.result   = rounded;
    rif.in_range = (rounded >= rif.lo) && (rounded <= rif.hi) && (rif.hi >= rif.lo);
  end
endmodule

// ### verilog/aoic_top.sv
/*
  Command engine for area-of-interest and tap settings and the offset
  calibration start. Software writes a three-letter command code and an
  argument over classic Wishbone and reads back settings and a prompt code.
  Assumes one 125 MHz clock MCLK and an asynchronous active-low RESETN.
*/
// What this block does
// - Height is accepted from 2 up to the maximum height and kept even.
// - Width is accepted from 512 up to a maximum set by model and aspect ratio.
// - Width is kept at multiples of 128.
// - Vertical offset is limited to 0 .. max height minus height, in steps of 2.
// - Horizontal offset is limited to 0 .. max width minus width, in steps of 128.
// - Values off the step grid are rounded to the nearest step, not rejected.
// - A change of aspect ratio refits height, width and offsets to the new limits.
// - Offset calibration runs only in the calibration flat-field mode, else it is refused.
// - Only 8 or 10 link taps are accepted.
// - Each finished command leaves a ready prompt, OK or an error code.
// - Command names match regardless of letter case.
`timescale 1ns/10ps
module aoic_top
  import aoic_pkg::*;
#(
  parameter logic [15:0] MAX_H_WIDE  = 16'h0400,
  parameter logic [15:0] MAX_W_WIDE  = 16'h1000,
  parameter logic [15:0] MAX_H_TALL  = 16'h0800,
  parameter logic [15:0] MAX_W_TALL  = 16'h0800,
  parameter int          CAL_CYCLES  = AOIC_CAL_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        RESETN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             CAL_RUN,
  output logic      [3:0]  TAP_COUNT
);
  // Elaboration check: the rounding helper only serves limits that sit on the step grid
  if (CAL_CYCLES < 1 || MAX_H_WIDE[0] || MAX_H_TALL[0]
      || MAX_W_WIDE[6:0] != 7'h00 || MAX_W_TALL[6:0] != 7'h00
      || MAX_W_WIDE < AOIC_MIN_WIDTH || MAX_W_TALL < AOIC_MIN_WIDTH) begin : g_bad_param
    $error("aoic_top parameters out of range");
  end

  aoic_round_if rif ();
  aoic_round u_round (.rif(rif));

  aoic_state_t state;
  logic [23:0] cmd;
  logic [15:0] arg;
  logic        go;
  logic [15:0] height;
  logic [15:0] width;
  logic [15:0] offy;
  logic [15:0] offx;
  logic [1:0]  ffm;
  logic        aspect;
  logic        ready;
  logic [2:0]  prompt;
  logic [31:0] cal_cnt;
  logic [1:0]  fit_step;
  logic        wr;
  logic [23:0] cmd_lc;
  logic [15:0] max_h;
  logic [15:0] max_w;

  assign wr     = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
  assign cmd_lc = cmd | AOIC_CASE_MASK;
  assign max_h  = aspect ? MAX_H_TALL : MAX_H_WIDE;
  assign max_w  = aspect ? MAX_W_TALL : MAX_W_WIDE;
  assign CAL_RUN = (state == AOIC_S_CALIB);

  // Single-cycle acknowledge, dropped the cycle after it is given
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
    end
  end

  // Read mux; unmapped offsets read zero
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      WB_DAT_O <= 32'h00000000;
    end else if (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_WE_I) begin
      case (WB_ADR_I)
        AOIC_REG_CMD:    WB_DAT_O <= {8'h00, cmd};
        AOIC_REG_ARG:    WB_DAT_O <= {16'h0000, arg};
        AOIC_REG_STATUS: WB_DAT_O <= {25'h0000000, prompt, 2'h0, ready, (state != AOIC_S_IDLE)};
        AOIC_REG_HEIGHT: WB_DAT_O <= {16'h0000, height};
        AOIC_REG_WIDTH:  WB_DAT_O <= {16'h0000, width};
        AOIC_REG_OFFY:   WB_DAT_O <= {16'h0000, offy};
        AOIC_REG_OFFX:   WB_DAT_O <= {16'h0000, offx};
        AOIC_REG_TAPS:   WB_DAT_O <= {28'h0000000, TAP_COUNT};
        AOIC_REG_MODE:   WB_DAT_O <= {27'h0000000, aspect, 2'h0, ffm};
        AOIC_REG_LIMITS: WB_DAT_O <= {max_w, max_h};
        default:         WB_DAT_O <= 32'h00000000;
      endcase
    end
  end

  // Command and argument capture; a write to the command word starts it.
  // Writes while busy are ignored so a running command keeps its inputs.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      cmd <= 24'h000000;
      arg <= 16'h0000;
      go  <= 1'b0;
    end else begin
      go <= 1'b0;
      if (wr && state == AOIC_S_IDLE && !go) begin
        if (WB_ADR_I == AOIC_REG_ARG) begin
          if (WB_SEL_I[0]) arg[7:0]  <= WB_DAT_I[7:0];
          if (WB_SEL_I[1]) arg[15:8] <= WB_DAT_I[15:8];
        end
        if (WB_ADR_I == AOIC_REG_CMD && WB_SEL_I[2:0] == 3'b111) begin
          cmd <= WB_DAT_I[23:0];
          go  <= 1'b1;
        end
      end
    end
  end

  // Flat-field mode and aspect ratio; an aspect change triggers a refit
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ffm    <= AOIC_FFM_OFF;
      aspect <= 1'b0;
    end else if (wr && state == AOIC_S_IDLE && WB_ADR_I == AOIC_REG_MODE && WB_SEL_I[0]) begin
      ffm    <= WB_DAT_I[AOIC_MODE_FFM_LSB +: 2];
      aspect <= WB_DAT_I[AOIC_MODE_ASPECT_LSB];
    end
  end

  logic aspect_d;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      aspect_d <= 1'b0;
    end else begin
      aspect_d <= aspect;
    end
  end

  // Drive the rounding helper from the command, or from the refit step
  always_comb begin
    rif.value = arg;
    rif.step  = AOIC_STEP_V;
    rif.lo    = 16'h0000;
    rif.hi    = 16'h0000;
    if (state == AOIC_S_FIT) begin
      case (fit_step)
        2'd0: begin rif.value = height; rif.lo = AOIC_MIN_HEIGHT; rif.hi = max_h; end
        2'd1: begin rif.value = width; rif.step = AOIC_STEP_H; rif.lo = AOIC_MIN_WIDTH; rif.hi = max_w; end
        2'd2: begin rif.value = offy; rif.hi = max_h - height; end
        default: begin rif.value = offx; rif.step = AOIC_STEP_H; rif.hi = max_w - width; end
      endcase
    end else if (cmd_lc == AOIC_CMD_WIDTH) begin
      rif.step = AOIC_STEP_H;
      rif.lo   = AOIC_MIN_WIDTH;
      rif.hi   = max_w;
    end else if (cmd_lc == AOIC_CMD_OFFY) begin
      rif.hi = max_h - height;
    end else if (cmd_lc == AOIC_CMD_OFFX) begin
      rif.step = AOIC_STEP_H;
      rif.hi   = max_w - width;
    end else begin
      rif.lo = AOIC_MIN_HEIGHT;
      rif.hi = max_h;
    end
  end

  // Refit clamp: fall back to the nearest limit when out of range
  logic [15:0] fit_val;
  always_comb begin
    if (rif.in_range) begin
      fit_val = rif.result;
    end else if (rif.result < rif.lo || rif.hi < rif.lo) begin
      fit_val = rif.lo;
    end else begin
      fit_val = rif.hi;
    end
  end

  // Command sequencer
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state     <= AOIC_S_IDLE;
      ready     <= 1'b1;
      prompt    <= AOIC_PR_OK;
      cal_cnt   <= 32'h00000000;
      fit_step  <= 2'd0;
      height    <= AOIC_MIN_HEIGHT;
      width     <= AOIC_MIN_WIDTH;
      offy      <= 16'h0000;
      offx      <= 16'h0000;
      TAP_COUNT <= AOIC_TAPS_8;
    end else begin
      case (state)
        AOIC_S_IDLE: begin
          if (aspect != aspect_d) begin
            state    <= AOIC_S_FIT;
            fit_step <= 2'd0;
          end else if (go) begin
            state <= AOIC_S_EXEC;
            ready <= 1'b0;
          end
        end
        AOIC_S_EXEC: begin
          state  <= AOIC_S_IDLE;
          ready  <= 1'b1;
          prompt <= AOIC_PR_OK;
          case (cmd_lc)
            AOIC_CMD_HEIGHT, AOIC_CMD_WIDTH, AOIC_CMD_OFFY, AOIC_CMD_OFFX: begin
              if (!rif.in_range) begin
                prompt <= AOIC_PR_RANGE;
              end else if (cmd_lc == AOIC_CMD_HEIGHT) begin
                height <= rif.result;
              end else if (cmd_lc == AOIC_CMD_WIDTH) begin
                width <= rif.result;
              end else if (cmd_lc == AOIC_CMD_OFFY) begin
                offy <= rif.result;
              end else begin
                offx <= rif.result;
              end
            end
            AOIC_CMD_CALIB: begin
              if (ffm == AOIC_FFM_CAL) begin
                state   <= AOIC_S_CALIB;
                ready   <= 1'b0;
                cal_cnt <= 32'h00000000;
              end else begin
                prompt <= AOIC_PR_NOTAVL;
              end
            end
            AOIC_CMD_TAPS: begin
              if (arg == 16'h0008 || arg == 16'h000a) begin
                TAP_COUNT <= arg[3:0];
              end else begin
                prompt <= AOIC_PR_RANGE;
              end
            end
            default: prompt <= AOIC_PR_UNKNOWN;
          endcase
        end
        AOIC_S_CALIB: begin
          // Stands in for the averaging pass run by the pixel datapath
          if (cal_cnt == 32'(CAL_CYCLES - 1)) begin
            state <= AOIC_S_IDLE;
            ready <= 1'b1;
          end else begin
            cal_cnt <= cal_cnt + 32'h00000001;
          end
        end
        AOIC_S_FIT: begin
          // Height and width first, since the offset limits depend on them
          case (fit_step)
            2'd0: height <= fit_val;
            2'd1: width  <= fit_val;
            2'd2: offy   <= fit_val;
            default: offx <= fit_val;
          endcase
          fit_step <= fit_step + 2'd1;
          if (fit_step == 2'd3) state <= AOIC_S_IDLE;
        end
        default: state <= AOIC_S_IDLE;
      endcase
    end
  end
endmodule

// ### sim/aoic_chk.sv
/* Checker for aoic_top: bus handshake, tap output and calibration run.
   Assumes it is bound to aoic_top and sees only its ports. */
`timescale 1ns/10ps
module aoic_chk #(
  parameter int CAL_CYCLES = 20
) (
  input wire logic        MCLK,
  input wire logic        RESETN,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        CAL_RUN,
  input wire logic [3:0]  TAP_COUNT
);
  logic [31:0] run_len;
  logic [3:0]  since_wr;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // Cycles high in the current calibration run
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) run_len <= 32'h0;
    else run_len <= CAL_RUN ? run_len + 32'h1 : 32'h0;
  end
  // Cycles since the last acked write; saturates so it cannot wrap
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) since_wr <= 4'hf;
    else if (WB_ACK_O && WB_WE_I) since_wr <= 4'h0;
    else if (since_wr != 4'hf) since_wr <= since_wr + 4'h1;
  end
  chk_ack_one: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack missing");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
  chk_ack_cause: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O) else $error("ack without request");
  chk_dat_hold: assert property ($changed(WB_DAT_O) |-> WB_ACK_O && !WB_WE_I) else $error("read data moved");
  chk_taps_legal: assert property (TAP_COUNT == 4'h8 || TAP_COUNT == 4'ha) else $error("bad taps");
  chk_taps_cause: assert property ($changed(TAP_COUNT) |-> since_wr <= 4'h5) else $error("taps moved");
  chk_cal_cause: assert property ($rose(CAL_RUN) |-> since_wr <= 4'h5) else $error("stray cal");
  chk_cal_len: assert property ($fell(CAL_RUN) |-> run_len == CAL_CYCLES) else $error("cal length");
  cov_cal_run: cover property ($fell(CAL_RUN));
  cov_taps_ten: cover property (TAP_COUNT == 4'ha);
  cov_read: cover property (WB_ACK_O && !WB_WE_I);
endmodule
bind aoic_top aoic_chk #(.CAL_CYCLES(CAL_CYCLES)) aoic_chk_inst (
  .MCLK(MCLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CAL_RUN(CAL_RUN), .TAP_COUNT(TAP_COUNT)
);

// ### sim/aoic_host.sv
/* Host console model: classic Wishbone master issuing commands and polling.
   Assumes each task is entered right after a rising edge of clk. */
`timescale 1ns/10ps
module aoic_host
  import aoic_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      wdat
);
  logic [3:0] grabber_taps;
  // Idle bus at time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    grabber_taps = 4'h8;
  end
  // One cycle; released address and data lines are inverted so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~a;
    wdat <= ~d;
    @(posedge clk);
  endtask
  // No limit of its own: a calibration may run very long
  task automatic run_cmd(input logic [23:0] code, input logic [15:0] arg, output logic [31:0] st);
    xfer(1'b1, AOIC_REG_ARG, {16'h0, arg}, st);
    xfer(1'b1, AOIC_REG_CMD, {8'h0, code}, st);
    repeat (2) @(posedge clk);
    st = 32'h1;
    while (st[0] !== 1'b0) xfer(1'b0, AOIC_REG_STATUS, 32'h0, st);
    // Grabber follows the accepted tap count
    if ((code | AOIC_CASE_MASK) == AOIC_CMD_TAPS && st[6:4] == AOIC_PR_OK) grabber_taps = arg[3:0];
  endtask
endmodule

// ### sim/tb_top.sv
/* Self-checking bench for aoic_top: commands go through the host model,
   settings, prompts and pins are judged. Assumes the bound checker. */
`timescale 1ns/10ps
module tb_top;
  import aoic_pkg::*;
  localparam int CAL_N = 20;
  logic        MCLK, RESETN, cyc, stb, we, ack, cal_run;
  logic [7:0]  adr;
  logic [3:0]  sel, taps;
  logic [31:0] wdat, rdat, q;
  int          fail_count, total_checks, cal_seen;
  aoic_top #(.CAL_CYCLES(CAL_N)) aoic_top_inst (
    .MCLK(MCLK), .RESETN(RESETN), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .CAL_RUN(cal_run), .TAP_COUNT(taps)
  );
  aoic_host aoic_host_inst (
    .clk(MCLK), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat)
  );
  // 125 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  // Calibration length as seen on the pin
  always @(posedge MCLK) if (cal_run === 1'b1) cal_seen <= cal_seen + 1;
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    aoic_host_inst.xfer(1'b0, a, 32'h0, q);
    chk(n, q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    aoic_host_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic cmd(input logic [23:0] c, input logic [15:0] a, input logic [2:0] pr);
    logic [31:0] st;
    aoic_host_inst.run_cmd(c, a, st);
    chk("prompt", {29'h0, st[6:4]}, {29'h0, pr});
    chk("ready", {31'h0, st[1]}, 32'h1);
  endtask
  task automatic t_reset;
    rd(AOIC_REG_HEIGHT, 32'h2, "height");
    rd(AOIC_REG_WIDTH, 32'h200, "width");
    rd(AOIC_REG_OFFY, 32'h0, "offy");
    rd(AOIC_REG_OFFX, 32'h0, "offx");
    rd(AOIC_REG_STATUS, 32'h2, "status");
    rd(8'h40, 32'h0, "unmapped");
    chk("tap pin", {28'h0, taps}, 32'h8);
  endtask
  // Minimum boundary, then values either side of the limits, the upper one off-grid
  task automatic t_height;
    cmd(24'h414948, 16'h1, AOIC_PR_OK);
    cmd(AOIC_CMD_HEIGHT, 16'h0, AOIC_PR_RANGE);
    cmd(AOIC_CMD_HEIGHT, 16'h401, AOIC_PR_RANGE);
    rd(AOIC_REG_HEIGHT, 32'h2, "height");
    cmd(AOIC_CMD_HEIGHT, 16'h5, AOIC_PR_OK);
    rd(AOIC_REG_HEIGHT, 32'h6, "height");
  endtask
  task automatic t_width;
    cmd(AOIC_CMD_WIDTH, 16'h2bc, AOIC_PR_OK);
    cmd(AOIC_CMD_WIDTH, 16'h190, AOIC_PR_RANGE);
    rd(AOIC_REG_WIDTH, 32'h280, "width");
  endtask
  task automatic t_offs;
    cmd(AOIC_CMD_OFFY, 16'h3fb, AOIC_PR_RANGE);
    cmd(AOIC_CMD_OFFY, 16'h3f9, AOIC_PR_OK);
    rd(AOIC_REG_OFFY, 32'h3fa, "offy");
    cmd(24'h416958, 16'hd80, AOIC_PR_OK);
    cmd(AOIC_CMD_OFFX, 16'hdc0, AOIC_PR_RANGE);
    rd(AOIC_REG_OFFX, 32'hd80, "offx");
    cmd(24'h7a7a7a, 16'h0, AOIC_PR_UNKNOWN);
  endtask
  // Tall aspect shrinks the width limit, so the horizontal offset must move
  task automatic t_aspect;
    wr(AOIC_REG_MODE, 32'h10);
    repeat (6) @(posedge MCLK);
    rd(AOIC_REG_LIMITS, 32'h08000800, "limits");
    rd(AOIC_REG_OFFX, 32'h580, "offx");
    rd(AOIC_REG_OFFY, 32'h3fa, "offy");
    rd(AOIC_REG_WIDTH, 32'h280, "width");
  endtask
  task automatic t_calib;
    cal_seen = 0;
    cmd(AOIC_CMD_CALIB, 16'h0, AOIC_PR_NOTAVL);
    chk("cal refused", cal_seen, 32'h0);
    // Flat-field on is not the calibration setting, so it must refuse too
    wr(AOIC_REG_MODE, 32'h11);
    rd(AOIC_REG_MODE, 32'h11, "mode");
    cmd(AOIC_CMD_CALIB, 16'h0, AOIC_PR_NOTAVL);
    chk("cal refused", cal_seen, 32'h0);
    wr(AOIC_REG_MODE, 32'h12);
    cmd(AOIC_CMD_CALIB, 16'h0, AOIC_PR_OK);
    chk("cal length", cal_seen, CAL_N);
  endtask
  task automatic t_taps;
    wr(AOIC_REG_TAPS, 32'ha);
    rd(AOIC_REG_TAPS, 32'h8, "taps ro");
    cmd(AOIC_CMD_TAPS, 16'ha, AOIC_PR_OK);
    chk("tap pin", {28'h0, taps}, {28'h0, aoic_host_inst.grabber_taps});
    cmd(AOIC_CMD_TAPS, 16'h9, AOIC_PR_RANGE);
    chk("tap pin", {28'h0, taps}, 32'ha);
    cmd(24'h434c4d, 16'h8, AOIC_PR_OK);
    chk("tap pin", {28'h0, taps}, 32'h8);
  endtask
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    fail_count = 0;
    total_checks = 0;
    cal_seen = 0;
    RESETN = 1'b0;
    repeat (20) @(posedge MCLK);
    RESETN <= 1'b1;
    @(posedge MCLK);
    t_reset;
    t_height;
    t_width;
    t_offs;
    t_aspect;
    t_calib;
    t_taps;
    end_sim;
  end
  // Watchdog: the whole run needs a few thousand cycles at most
  initial begin
    repeat (20000) @(posedge MCLK);
    fail_count++;
    end_sim;
  end
endmodule
